// File: rtl/sip_pkg.sv
// constants, widths and helpers shared by the serial-in parallel-out shifter
// ================================================================
package sip_pkg;

    // ================================================================
    // structure
    localparam int SIP_STAGES = 8; // length of the shift chain
    localparam int SIP_FIFO_DEPTH = 32; // snapshot buffer depth
    localparam int SIP_FIFO_WIDTH = SIP_STAGES; // one snapshot per word

    // ================================================================
    // reset and clear values
    localparam logic [SIP_STAGES-1:0] SIP_TAPS_CLEAR = 8'h00; // all stages low
    localparam logic SIP_CLK_PREV_RST = 1'h1; // no false rise after reset
    localparam logic SIP_FLAG_CLEAR = 1'h0; // idle value of flags

    // ================================================================
    // gated serial entry: low on either input blocks the other
    function automatic logic sip_gate(input logic ser_a, input logic ser_b);
        sip_gate = ser_a & ser_b;
    endfunction

endpackage

// File: rtl/sip_fifo.sv
// snapshot buffer with registered outputs, valid and ready on both sides
`timescale 1ns/1ps
module sip_fifo #(
    parameter int WIDTH = sip_pkg::SIP_FIFO_WIDTH,
    parameter int DEPTH = sip_pkg::SIP_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    import sip_pkg::*;

    // depth must be a power of two so pointers wrap on their own
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    // ================================================================
    // whole state of the buffer
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem; // storage words
        logic [AW-1:0] wr_ptr; // next slot to fill
        logic [AW-1:0] rd_ptr; // next slot to drain
        logic [CW-1:0] count; // words held in storage
        logic out_valid; // output stage holds a word
        logic [WIDTH-1:0] out_data; // output stage word
        logic in_ready; // room for one more word
    } sip_fifo_state_t;

    sip_fifo_state_t st_reg;
    sip_fifo_state_t st_next;
    logic push;
    logic pop;

    // ================================================================
    // next state: fill, drain into output stage, flush
    always_comb begin
        st_next = st_reg;
        push = in_valid & st_reg.in_ready;
        pop = (st_reg.count != '0) & (~st_reg.out_valid | out_ready);
        // consumer took the output word
        if (st_reg.out_valid & out_ready) begin
            st_next.out_valid = 1'h0;
        end
        // refill output stage from storage
        if (pop) begin
            st_next.out_data = st_reg.mem[st_reg.rd_ptr];
            st_next.out_valid = 1'h1;
            st_next.rd_ptr = st_reg.rd_ptr + 1'h1;
        end
        // accept a new word
        if (push) begin
            st_next.mem[st_reg.wr_ptr] = in_data;
            st_next.wr_ptr = st_reg.wr_ptr + 1'h1;
        end
        // occupancy bookkeeping
        if (push & ~pop) begin
            st_next.count = st_reg.count + 1'h1;
        end else if (pop & ~push) begin
            st_next.count = st_reg.count - 1'h1;
        end
        // flush drops everything held
        if (flush) begin
            st_next.wr_ptr = '0;
            st_next.rd_ptr = '0;
            st_next.count = '0;
            st_next.out_valid = 1'h0;
        end
        st_next.in_ready = (st_next.count != FULL_COUNT);
    end

    // ================================================================
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.in_ready <= 1'h1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign in_ready = st_reg.in_ready;
    assign out_valid = st_reg.out_valid;
    assign out_data = st_reg.out_data;

endmodule

// File: rtl/sip_shifter.sv
// eight-stage serial-in parallel-out shifter with snapshot buffer
`timescale 1ns/1ps
module sip_shifter (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic SER_A,
    input wire logic SER_B,
    input wire logic SHIFT_CLK,
    input wire logic ASYNC_CLEAR_N,
    output logic TAP_ONE,
    output logic TAP_TWO,
    output logic TAP_THREE,
    output logic TAP_FOUR,
    output logic TAP_FIVE,
    output logic TAP_SIX,
    output logic TAP_SEVEN,
    output logic TAP_EIGHT,
    output logic [sip_pkg::SIP_FIFO_WIDTH-1:0] WORD_DATA,
    output logic WORD_VALID,
    input wire logic WORD_READY,
    output logic CAPTURE_READY,
    output logic WORD_DROPPED
);
    import sip_pkg::*;

    // ================================================================
    // whole state of the shifter
    typedef struct packed {
        logic [SIP_STAGES-1:0] taps; // stage one in bit 0
        logic clk_prev; // shift clock seen last cycle
        logic push; // snapshot offered to buffer
        logic [SIP_STAGES-1:0] push_data; // snapshot word
        logic dropped; // sticky: snapshot lost to a full buffer
    } sip_state_t;

    sip_state_t st_reg;
    sip_state_t st_next;
    logic rise; // shift clock low-to-high this cycle
    logic fall; // shift clock high-to-low this cycle
    logic clear_act; // clear pin asserted, taken on the system clock
    logic buf_ready; // buffer can take a word

    assign rise = SHIFT_CLK & ~st_reg.clk_prev;
    assign fall = ~SHIFT_CLK & st_reg.clk_prev;
    assign clear_act = ~ASYNC_CLEAR_N;

    // ================================================================
    // next state: clear, shift, snapshot
    always_comb begin
        st_next = st_reg;
        st_next.clk_prev = SHIFT_CLK;
        st_next.push = SIP_FLAG_CLEAR;
        if (clear_act) begin
            // clear overrides clock and serial inputs
            st_next.taps = SIP_TAPS_CLEAR;
            st_next.dropped = SIP_FLAG_CLEAR;
        end else if (rise) begin
            // one-position shift, gated entry into stage one
            st_next.taps = {st_reg.taps[SIP_STAGES-2:0],
                            sip_gate(SER_A, SER_B)};
            st_next.push = 1'h1;
            st_next.push_data = st_next.taps;
        end
        // otherwise every stage holds
        // a refused snapshot is remembered; the set wins over a clear in
        // the same cycle so that a lost word is never hidden
        if (st_reg.push & ~buf_ready) begin
            st_next.dropped = 1'h1;
        end
    end

    // ================================================================
    // state register
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_reg.taps <= SIP_TAPS_CLEAR;
            st_reg.clk_prev <= SIP_CLK_PREV_RST;
            st_reg.push <= SIP_FLAG_CLEAR;
            st_reg.push_data <= SIP_TAPS_CLEAR;
            st_reg.dropped <= SIP_FLAG_CLEAR;
        end else begin
            st_reg <= st_next;
        end
    end

    // ================================================================
    // snapshot buffer, flushed by clear
    sip_fifo #(
        .WIDTH(SIP_FIFO_WIDTH),
        .DEPTH(SIP_FIFO_DEPTH)
    ) i_sip_fifo (
        .clk(MCLK),
        .rst_n(RESET_N),
        // words leave in shift order; a full buffer drops, never stalls
        .flush(clear_act),
        .in_valid(st_reg.push),
        .in_data(st_reg.push_data),
        .in_ready(buf_ready),
        .out_valid(WORD_VALID),
        .out_data(WORD_DATA),
        .out_ready(WORD_READY)
    );

    // ================================================================
    // parallel stage outputs from the chain flops, plus buffer ready and the lost-snapshot flag
    assign TAP_ONE = st_reg.taps[0];
    assign TAP_TWO = st_reg.taps[1];
    assign TAP_THREE = st_reg.taps[2];
    assign TAP_FOUR = st_reg.taps[3];
    assign TAP_FIVE = st_reg.taps[4];
    assign TAP_SIX = st_reg.taps[5];
    assign TAP_SEVEN = st_reg.taps[6];
    assign TAP_EIGHT = st_reg.taps[7];
    assign CAPTURE_READY = buf_ready;
    assign WORD_DROPPED = st_reg.dropped;

    // ================================================================
    // checks on the chain
    property p_clear_zero;
        @(posedge MCLK) disable iff (!RESET_N)
        clear_act |=> ({TAP_EIGHT, TAP_SEVEN, TAP_SIX, TAP_FIVE,
                      TAP_FOUR, TAP_THREE, TAP_TWO, TAP_ONE} == SIP_TAPS_CLEAR);
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("stages not low after clear");

    property p_clear_held;
        @(posedge MCLK) disable iff (!RESET_N)
        clear_act [*3] |=> (st_reg.taps == SIP_TAPS_CLEAR) && !WORD_VALID;
    endproperty
    a_clear_held: assert property (p_clear_held)
        else $error("clear held but chain or buffer not empty");

    property p_entry_low;
        @(posedge MCLK) disable iff (!RESET_N)
        (!clear_act && rise && (!SER_A || !SER_B)) |=> !TAP_ONE;
    endproperty
    a_entry_low: assert property (p_entry_low)
        else $error("low serial input did not load zero");

    property p_entry_high;
        @(posedge MCLK) disable iff (!RESET_N)
        (!clear_act && rise && SER_A && SER_B) |=> TAP_ONE;
    endproperty
    a_entry_high: assert property (p_entry_high)
        else $error("both inputs high did not load one");

    property p_shift_up;
        @(posedge MCLK) disable iff (!RESET_N)
        (!clear_act && rise) |=>
            (st_reg.taps[SIP_STAGES-1:1] == $past(st_reg.taps[SIP_STAGES-2:0]));
    endproperty
    a_shift_up: assert property (p_shift_up)
        else $error("stages did not shift by one");

    property p_fall_quiet;
        @(posedge MCLK) disable iff (!RESET_N)
        (!clear_act && fall) |=> $stable(st_reg.taps) && !st_reg.push;
    endproperty
    a_fall_quiet: assert property (p_fall_quiet)
        else $error("falling shift clock changed the chain");

    property p_hold;
        @(posedge MCLK) disable iff (!RESET_N)
        (!clear_act && !rise) |=> $stable(st_reg.taps);
    endproperty
    a_hold: assert property (p_hold)
        else $error("chain moved without a rising shift clock");

    property p_snapshot;
        @(posedge MCLK) disable iff (!RESET_N)
        (!clear_act && rise) |=> st_reg.push && (st_reg.push_data == st_reg.taps);
    endproperty
    a_snapshot: assert property (p_snapshot)
        else $error("parallel snapshot missing or wrong");

    property p_drop_flag;
        @(posedge MCLK) disable iff (!RESET_N)
        (st_reg.push && !buf_ready) |=> WORD_DROPPED;
    endproperty
    a_drop_flag: assert property (p_drop_flag)
        else $error("refused snapshot not flagged");

    property p_clear_over_rise;
        @(posedge MCLK) disable iff (!RESET_N)
        (clear_act && rise) |=> !st_reg.push && (st_reg.taps == SIP_TAPS_CLEAR);
    endproperty
    a_clear_over_rise: assert property (p_clear_over_rise)
        else $error("rise under clear still shifted the chain");

    property p_push_on_rise_only;
        @(posedge MCLK) disable iff (!RESET_N)
        (clear_act || !rise) |=> !st_reg.push;
    endproperty
    a_push_on_rise_only: assert property (p_push_on_rise_only)
        else $error("snapshot taken without a rising shift clock");

    // ================================================================
    // checks on the snapshot buffer

    property p_clear_flush;
        @(posedge MCLK) disable iff (!RESET_N)
        clear_act |=> !WORD_VALID && CAPTURE_READY;
    endproperty
    a_clear_flush: assert property (p_clear_flush)
        else $error("clear left words in the buffer");

    property p_drop_sticky;
        @(posedge MCLK) disable iff (!RESET_N)
        (WORD_DROPPED && !clear_act) |=> WORD_DROPPED;
    endproperty
    a_drop_sticky: assert property (p_drop_sticky)
        else $error("lost-snapshot flag fell without a clear");

    property p_word_hold;
        @(posedge MCLK) disable iff (!RESET_N)
        (WORD_VALID && !WORD_READY && !clear_act) |=> WORD_VALID && $stable(WORD_DATA);
    endproperty
    a_word_hold: assert property (p_word_hold)
        else $error("offered word changed before it was taken");

endmodule

// File: sim/sip_ctrl_model.sv
// controller model driving the serial inputs and the shift clock
`timescale 1ns/1ps
module sip_ctrl_model (
    input wire logic mclk,
    output logic ser_a,
    output logic ser_b,
    output logic shift_clk
);
    // ================================================================
    // idle levels at time zero
    initial begin
        ser_a = 1'h0;
        ser_b = 1'h0;
        shift_clk = 1'h0;
    end

    // ================================================================
    // one bit: a low phase, then the rise with data set up for it
    task automatic send_bit(input logic a, input logic b);
        @(negedge mclk);
        shift_clk = 1'h0;
        @(negedge mclk);
        ser_a = a;
        ser_b = b;
        shift_clk = 1'h1;
        @(negedge mclk);
        ser_a = ~a; // data may move once the rise is taken
        ser_b = ~b;
    endtask

    // clock falls and stays low while the data lines wander
    task automatic idle_low(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge mclk);
            shift_clk = 1'h0;
            ser_a = 1'($urandom_range(1));
            ser_b = 1'($urandom_range(1));
        end
    endtask
endmodule

// File: sim/sip_shifter_tb.sv
// self-checking bench for the serial-in parallel-out shifter
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); end end
module sip_shifter_tb;
    import sip_pkg::*;

    // ================================================================
    // stimulus and observation signals
    logic mclk = 1'h0;
    logic reset_n = 1'h0;
    logic clear_n = 1'h1;
    logic word_ready = 1'h0;
    logic rdy_en = 1'h0; // lets the consumer take words
    wire logic ser_a, ser_b, shift_clk;
    wire logic [7:0] taps; // bit0 = stage one
    wire logic [SIP_FIFO_WIDTH-1:0] word_data;
    wire logic word_valid, capture_ready, word_dropped;
    logic [7:0] model_taps = 8'h00; // expected chain contents
    logic [7:0] exp_q[$]; // expected buffered words
    logic [7:0] exp_w; // oldest note taken off the queue
    logic ready_pick; // consumer readiness picked at this fall
    int fail_count = 0;
    int total_checks = 0;

    always #4 mclk = ~mclk;

    sip_ctrl_model i_sip_ctrl_model (.mclk(mclk), .ser_a(ser_a), .ser_b(ser_b),
        .shift_clk(shift_clk));

    sip_shifter i_sip_shifter (.MCLK(mclk), .RESET_N(reset_n), .SER_A(ser_a),
        .SER_B(ser_b), .SHIFT_CLK(shift_clk), .ASYNC_CLEAR_N(clear_n),
        .TAP_ONE(taps[0]), .TAP_TWO(taps[1]), .TAP_THREE(taps[2]), .TAP_FOUR(taps[3]),
        .TAP_FIVE(taps[4]), .TAP_SIX(taps[5]), .TAP_SEVEN(taps[6]), .TAP_EIGHT(taps[7]),
        .WORD_DATA(word_data), .WORD_VALID(word_valid), .WORD_READY(word_ready),
        .CAPTURE_READY(capture_ready), .WORD_DROPPED(word_dropped));

    // ================================================================
    // consumer and watcher: readiness picked at each fall; a word offered
    // while ready is taken at the next rise, so it is compared here, where
    // valid and data are settled and cannot move before that rise
    always @(negedge mclk) begin
        ready_pick = rdy_en ? 1'($urandom_range(1)) : 1'h0;
        word_ready <= ready_pick;
        if (ready_pick && word_valid === 1'h1) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("CHECK FAILED t=%0t unexpected word %h", $time, word_data);
            end else begin
                exp_w = exp_q.pop_front();
                `CHK(word_data, exp_w)
            end
        end
    end

    // ================================================================
    // helpers
    task automatic shift(input logic a, input logic b, input bit push);
        i_sip_ctrl_model.send_bit(a, b);
        model_taps = {model_taps[6:0], a & b};
        `CHK(taps, model_taps)
        if (push) begin
            exp_q.push_back(model_taps);
        end
    endtask

    // wait, bounded, until every noted word has been taken
    task automatic drain();
        rdy_en = 1'h1;
        for (int i = 0; i < 400 && (exp_q.size() != 0 || word_valid !== 1'h0); i++) begin
            @(negedge mclk);
        end
        `CHK(exp_q.size(), 0)
    endtask

    // clear held low across a rise; the chain and buffer empty out
    task automatic clear_pulse();
        @(negedge mclk);
        clear_n = 1'h0;
        i_sip_ctrl_model.send_bit(1'h1, 1'h1);
        repeat (3) @(negedge mclk);
        `CHK(taps, SIP_TAPS_CLEAR)
        clear_n = 1'h1;
        model_taps = SIP_TAPS_CLEAR;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ================================================================
    // watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        wrap_up();
    end

    // ================================================================
    // main sequence
    initial begin
        void'($urandom(32'h0c48e995));
        repeat (12) @(negedge mclk);
        reset_n = 1'h1;
        `CHK({taps, word_valid, capture_ready, word_dropped}, 11'h002)
        // every pair of serial levels, then random bits
        for (int c = 0; c < 4; c++) begin
            shift(c[1], c[0], 1'b1);
            `CHK(taps[0], c[1] & c[0])
        end
        rdy_en = 1'h1;
        for (int i = 0; i < 20; i++) begin
            shift(1'($urandom_range(1)), 1'($urandom_range(1)), 1'b1);
        end
        // fall and low level leave the chain alone
        i_sip_ctrl_model.idle_low(5);
        `CHK(taps, model_taps)
        drain();
        clear_pulse();
        `CHK(word_valid, 1'h0)
        // fill with the consumer stalled until a snapshot is lost
        rdy_en = 1'h0;
        for (int i = 0; i < 34; i++) begin
            shift(1'($urandom_range(1)), 1'($urandom_range(1)), i < 33);
        end
        repeat (2) @(negedge mclk);
        `CHK({word_dropped, capture_ready}, 2'h2)
        drain();
        `CHK(word_dropped, 1'h1)
        clear_pulse();
        `CHK({word_dropped, capture_ready}, 2'h1)
        wrap_up();
    end
endmodule
